// file: hw/modbus_pkg.sv
// Constants, carrier types and the CRC step for the serial-bus slave frame handler.
// Assumes a byte-level line interface that marks the end of each received frame.
`default_nettype none
package modbus_pkg;
  localparam logic [7:0] FC_READ_HOLD  = 8'h03;
  localparam logic [7:0] FC_READ_INPUT = 8'h04;
  localparam logic [7:0] FC_ACCESS     = 8'h05;
  localparam logic [7:0] FC_WRITE_ONE  = 8'h06;
  localparam logic [7:0] FC_SPECIAL    = 8'h09;
  localparam logic [7:0] FC_WRITE_MANY = 8'h10;
  localparam logic [7:0] SUB_ACC_CODE  = 8'h01;
  localparam logic [7:0] SUB_ACC_PAIR  = 8'h04;
  localparam logic [7:0] SUB_REMOTE    = 8'h30;
  localparam logic [7:0] CTL_START     = 8'h1A;
  localparam logic [7:0] CTL_STOP      = 8'h1B;
  localparam logic [7:0] EXC_FLAG      = 8'h80;
  localparam logic [7:0] EX_FUNC       = 8'h01;
  localparam logic [7:0] EX_ADDR       = 8'h02;
  localparam logic [7:0] EX_DATA       = 8'h03;
  localparam logic [7:0] EX_BUSY       = 8'h06;
  localparam logic [7:0] EX_NAK        = 8'h07;
  localparam logic [7:0] EX_LEN        = 8'h10;
  localparam logic [7:0] MAX_REGS      = 8'h7D;
  localparam logic [15:0] CRC_INIT     = 16'hFFFF;
  localparam logic [15:0] CRC_POLY     = 16'hA001;
  localparam logic [8:0] LEN_MIN       = 9'h004;
  localparam logic [8:0] LEN_READ      = 9'h008;
  localparam logic [8:0] LEN_ACC1      = 9'h008;
  localparam logic [8:0] LEN_ACC4      = 9'h00A;
  localparam logic [8:0] LEN_WR1       = 9'h008;
  localparam logic [8:0] LEN_SPECIAL   = 9'h006;
  localparam logic [8:0] LEN_WRM_HDR   = 9'h009;
  localparam logic [8:0] RPL_READ_HDR  = 9'h003;
  localparam logic [8:0] RPL_WRM       = 9'h006;
  localparam logic [8:0] RPL_EXC       = 9'h003;
  localparam logic [8:0] OFS_WR1_DATA  = 9'h004;
  localparam logic [8:0] OFS_WRM_DATA  = 9'h007;
  localparam logic [8:0] RX_DEPTH      = 9'h104;
  localparam int         TX_DEPTH      = 16;

  typedef enum logic [1:0] {OP_READ = 2'h0, OP_WRITE = 2'h1, OP_ACCESS = 2'h2} app_op_t;
  typedef enum logic [1:0] {MODE_ECHO = 2'h0, MODE_READ = 2'h1, MODE_EXC = 2'h2} reply_mode_t;
  typedef enum logic [2:0] {
    ST_RX = 3'h0, ST_CHK = 3'h1, ST_EXEC = 3'h3, ST_WAIT = 3'h2, ST_SEND = 3'h6
  } state_t;

  typedef struct packed {
    app_op_t     op;
    logic [15:0] addr;
    logic [15:0] data;
    logic [15:0] data2;
  } app_req_t;

  typedef struct packed {
    logic        ack;
    logic        err;
    logic [7:0]  exc;
    logic [15:0] rdata;
  } app_rsp_t;

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int k = 0; k < 8; k++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc_step
endpackage : modbus_pkg
`default_nettype wire

// file: hw/modbus_rtu_slave_frame_handler.sv
// Frame handler: buffers a query, checks it, serves it through the application port and
// queues the reply bytes into a transmit FIFO.
// Assumes the line layer gives one byte per rx_valid_i and pulses rx_end_i on inter-frame
// silence, and that the application answers each request with exactly one ack.
// How it works
// - Serve function codes 3,4,5,6,9,16.
// - Code 4 handled exactly like code 3.
// - Read query: addr, code, start, count, CRC.
// - Read count limited to 125 registers.
// - Read reply: addr, code, count, data, CRC.
// - Byte count is twice registers returned.
// - Access sub-function 1: sub, data, little-endian.
// - Access sub-function 1 reply echoes query.
// - Access sub-function 4: two words, echoed.
// - Single write: address, value, big-endian.
// - Single write reply repeats query fields.
// - Special sub-function 48 means remote start/stop.
// - Control byte 26 starts the motor.
// - Remote frame has no length fields.
// - Control byte 27 stops the motor.
// - CRC sent low byte first.
// - Exception reply sets code plus 0x80.
// - Exception codes 1,2,3,6,7,16.
`default_nettype none
module tx_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_sys_i,
  input  wire logic             reset_n_i,
  // Fill side.
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  // Drain side.
  output logic [WIDTH-1:0]      out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_r;
  logic [AW:0]      rd_r;
  logic [AW:0]      wr_nxt;
  logic [AW:0]      rd_nxt;
  logic             push;
  logic             valid_r;
  logic             valid_nxt;

  assign in_ready_o  = !((wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]));
  // A registered non-empty flag keeps the handler's valid output straight from a flop.
  assign out_valid_o = valid_r;
  assign out_data_o  = mem[rd_r[AW-1:0]];
  assign push        = in_valid_i && in_ready_o;

  always_comb begin
    wr_nxt = push ? wr_r + 1'b1 : wr_r;
    rd_nxt = (out_valid_o && out_ready_i) ? rd_r + 1'b1 : rd_r;
    valid_nxt = (wr_nxt != rd_nxt);
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_r    <= '0;
      rd_r    <= '0;
      valid_r <= 1'b0;
    end else begin
      wr_r    <= wr_nxt;
      rd_r    <= rd_nxt;
      valid_r <= valid_nxt;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      mem[wr_r[AW-1:0]] <= in_data_i;
    end
  end
endmodule : tx_fifo

module modbus_rtu_slave_frame_handler #(
  parameter int FIFO_DEPTH = modbus_pkg::TX_DEPTH
) (
  // Clock and reset.
  input  wire logic                 clk_sys_i,
  input  wire logic                 reset_n_i,
  // Received byte stream.
  input  wire logic [7:0]           rx_byte_i,
  input  wire logic                 rx_valid_i,
  input  wire logic                 rx_end_i,
  input  wire logic [7:0]           slave_addr_i,
  // Application register and access port.
  output modbus_pkg::app_req_t      app_req_o,
  output logic                      app_req_valid_o,
  input  wire modbus_pkg::app_rsp_t app_rsp_i,
  // Motor commands.
  output logic                      motor_start_o,
  output logic                      motor_stop_o,
  // Reply byte stream.
  output logic [7:0]                tx_byte_o,
  output logic                      tx_valid_o,
  input  wire logic                 tx_ready_i,
  // Status.
  output logic                      busy_o,
  output logic                      frame_drop_o
);
  localparam int RX_SIZE   = int'(modbus_pkg::RX_DEPTH);
  localparam int MAX_WORDS = int'(modbus_pkg::MAX_REGS);
  logic [7:0]              rx_buf [RX_SIZE];
  logic [15:0]             rd_mem [MAX_WORDS];

  modbus_pkg::state_t      state_r, state_nxt;
  modbus_pkg::reply_mode_t mode_r, mode_nxt;
  logic [8:0]              cnt_r, cnt_nxt, si_r, si_nxt, len_r, len_nxt;
  logic [15:0]             crc_r, crc_nxt;
  logic [7:0]              exc_r, exc_nxt, words_r, words_nxt, idx_r, idx_nxt;
  modbus_pkg::app_req_t    req_r, req_nxt;
  logic                    req_valid_r, req_valid_nxt;
  logic                    start_r, start_nxt, stop_r, stop_nxt;
  logic                    busy_r, busy_nxt, drop_r, drop_nxt;
  logic                    buf_we, mem_we, push, in_ready, frame_ok;
  logic [7:0]              fc, tx_sel, body_byte;
  logic [15:0]             num, sub, rd_word;
  logic [8:0]              didx, rofs;

  assign fc       = rx_buf[1];
  assign num      = {rx_buf[4], rx_buf[5]};
  assign sub      = {rx_buf[3], rx_buf[2]};
  assign frame_ok = (crc_r == 16'h0000) && (cnt_r >= modbus_pkg::LEN_MIN)
                    && (cnt_r < modbus_pkg::RX_DEPTH) && (rx_buf[0] == slave_addr_i);
  assign didx     = (fc == modbus_pkg::FC_WRITE_ONE) ? modbus_pkg::OFS_WR1_DATA
                    : modbus_pkg::OFS_WRM_DATA + {idx_r, 1'b0};
  assign rofs     = si_r - modbus_pkg::RPL_READ_HDR;
  assign rd_word  = rd_mem[rofs[7:1]];
  assign push     = (state_r == modbus_pkg::ST_SEND) && in_ready;
  assign buf_we   = (state_r == modbus_pkg::ST_RX) && rx_valid_i
                    && (cnt_r < modbus_pkg::RX_DEPTH);
  assign mem_we   = (state_r == modbus_pkg::ST_WAIT) && app_rsp_i.ack && !app_rsp_i.err
                    && (req_r.op == modbus_pkg::OP_READ);

  always_comb begin
    body_byte = rx_buf[si_r];
    case (mode_r)
      modbus_pkg::MODE_EXC: begin
        if (si_r == 9'h000) body_byte = rx_buf[0];
        else if (si_r == 9'h001) body_byte = fc | modbus_pkg::EXC_FLAG;
        else body_byte = exc_r;
      end
      modbus_pkg::MODE_READ: begin
        if (si_r == 9'h000) body_byte = rx_buf[0];
        else if (si_r == 9'h001) body_byte = fc;
        else if (si_r == 9'h002) body_byte = {words_r[6:0], 1'b0};
        else body_byte = rofs[0] ? rd_word[7:0] : rd_word[15:8];
      end
      default: body_byte = rx_buf[si_r];
    endcase
    if (si_r < len_r) tx_sel = body_byte;
    else if (si_r == len_r) tx_sel = crc_r[7:0];
    else tx_sel = crc_r[15:8];
  end

  always_comb begin
    state_nxt     = state_r;
    mode_nxt      = mode_r;
    cnt_nxt       = cnt_r;
    si_nxt        = si_r;
    len_nxt       = len_r;
    crc_nxt       = crc_r;
    exc_nxt       = exc_r;
    words_nxt     = words_r;
    idx_nxt       = idx_r;
    req_nxt       = req_r;
    req_valid_nxt = req_valid_r;
    start_nxt     = 1'b0;
    stop_nxt      = 1'b0;
    drop_nxt      = 1'b0;
    case (state_r)
      modbus_pkg::ST_RX: begin
        if (rx_valid_i) begin
          crc_nxt = modbus_pkg::crc_step(crc_r, rx_byte_i);
          if (cnt_r < modbus_pkg::RX_DEPTH) cnt_nxt = cnt_r + 9'h001;
        end
        if (rx_end_i) state_nxt = modbus_pkg::ST_CHK;
      end
      modbus_pkg::ST_CHK: begin
        crc_nxt   = modbus_pkg::CRC_INIT;
        si_nxt    = '0;
        idx_nxt   = '0;
        state_nxt = modbus_pkg::ST_SEND;
        mode_nxt  = modbus_pkg::MODE_EXC;
        len_nxt   = modbus_pkg::RPL_EXC;
        exc_nxt   = modbus_pkg::EX_DATA;
        words_nxt = num[7:0];
        if (!frame_ok) begin
          state_nxt = modbus_pkg::ST_RX;
          cnt_nxt   = '0;
          drop_nxt  = 1'b1;
        end else if (fc == modbus_pkg::FC_READ_HOLD || fc == modbus_pkg::FC_READ_INPUT) begin
          if (cnt_r == modbus_pkg::LEN_READ && num != 16'h0000) begin
            if (num > {8'h00, modbus_pkg::MAX_REGS}) exc_nxt = modbus_pkg::EX_LEN;
            else state_nxt = modbus_pkg::ST_EXEC;
          end
        end else if (fc == modbus_pkg::FC_ACCESS) begin
          req_nxt.data  = {rx_buf[5], rx_buf[4]};
          req_nxt.data2 = (sub == {8'h00, modbus_pkg::SUB_ACC_PAIR})
                          ? {rx_buf[7], rx_buf[6]} : 16'h0000;
          if ((sub == {8'h00, modbus_pkg::SUB_ACC_CODE} && cnt_r == modbus_pkg::LEN_ACC1)
              || (sub == {8'h00, modbus_pkg::SUB_ACC_PAIR} && cnt_r == modbus_pkg::LEN_ACC4))
            state_nxt = modbus_pkg::ST_EXEC;
        end else if (fc == modbus_pkg::FC_WRITE_ONE) begin
          words_nxt = 8'h01;
          if (cnt_r == modbus_pkg::LEN_WR1) state_nxt = modbus_pkg::ST_EXEC;
        end else if (fc == modbus_pkg::FC_SPECIAL) begin
          if (cnt_r == modbus_pkg::LEN_SPECIAL && rx_buf[2] == modbus_pkg::SUB_REMOTE
              && (rx_buf[3] == modbus_pkg::CTL_START || rx_buf[3] == modbus_pkg::CTL_STOP)) begin
            start_nxt = (rx_buf[3] == modbus_pkg::CTL_START);
            stop_nxt  = (rx_buf[3] == modbus_pkg::CTL_STOP);
            mode_nxt  = modbus_pkg::MODE_ECHO;
            len_nxt   = cnt_r - 9'h002;
          end
        end else if (fc == modbus_pkg::FC_WRITE_MANY) begin
          if (num == 16'h0000 || num > {8'h00, modbus_pkg::MAX_REGS}) begin
            if (num != 16'h0000) exc_nxt = modbus_pkg::EX_LEN;
          end else if (rx_buf[6] == {num[6:0], 1'b0}
                       && cnt_r == modbus_pkg::LEN_WRM_HDR + {num[7:0], 1'b0})
            state_nxt = modbus_pkg::ST_EXEC;
        end else begin
          exc_nxt = modbus_pkg::EX_FUNC;
        end
      end
      modbus_pkg::ST_EXEC: begin
        req_valid_nxt = 1'b1;
        req_nxt.addr  = {rx_buf[2], rx_buf[3]} + {8'h00, idx_r};
        if (fc == modbus_pkg::FC_ACCESS) begin
          req_nxt.op   = modbus_pkg::OP_ACCESS;
          req_nxt.addr = sub;
        end else if (fc == modbus_pkg::FC_READ_HOLD || fc == modbus_pkg::FC_READ_INPUT) begin
          req_nxt.op = modbus_pkg::OP_READ;
        end else begin
          req_nxt.op   = modbus_pkg::OP_WRITE;
          req_nxt.data = {rx_buf[didx], rx_buf[didx + 9'h001]};
        end
        state_nxt = modbus_pkg::ST_WAIT;
      end
      modbus_pkg::ST_WAIT: begin
        if (app_rsp_i.ack) begin
          req_valid_nxt = 1'b0;
          idx_nxt       = idx_r + 8'h01;
          state_nxt     = modbus_pkg::ST_EXEC;
          if (app_rsp_i.err) begin
            state_nxt = modbus_pkg::ST_SEND;
            mode_nxt  = modbus_pkg::MODE_EXC;
            len_nxt   = modbus_pkg::RPL_EXC;
            exc_nxt   = app_rsp_i.exc;
          end else if (idx_r + 8'h01 >= words_r || req_r.op == modbus_pkg::OP_ACCESS) begin
            state_nxt = modbus_pkg::ST_SEND;
            if (req_r.op == modbus_pkg::OP_READ) begin
              mode_nxt = modbus_pkg::MODE_READ;
              len_nxt  = modbus_pkg::RPL_READ_HDR + {words_r, 1'b0};
            end else begin
              mode_nxt = modbus_pkg::MODE_ECHO;
              len_nxt  = (fc == modbus_pkg::FC_WRITE_MANY) ? modbus_pkg::RPL_WRM
                         : cnt_r - 9'h002;
            end
          end
        end
      end
      modbus_pkg::ST_SEND: begin
        if (in_ready) begin
          si_nxt = si_r + 9'h001;
          if (si_r < len_r) crc_nxt = modbus_pkg::crc_step(crc_r, tx_sel);
          if (si_r == len_r + 9'h001) begin
            state_nxt = modbus_pkg::ST_RX;
            cnt_nxt   = '0;
            crc_nxt   = modbus_pkg::CRC_INIT;
          end
        end
      end
      default: state_nxt = modbus_pkg::ST_RX;
    endcase
    busy_nxt = (state_nxt != modbus_pkg::ST_RX);
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_r     <= modbus_pkg::ST_RX;
      mode_r      <= modbus_pkg::MODE_ECHO;
      cnt_r       <= '0;
      si_r        <= '0;
      len_r       <= '0;
      crc_r       <= modbus_pkg::CRC_INIT;
      exc_r       <= '0;
      words_r     <= '0;
      idx_r       <= '0;
      req_r       <= '0;
      req_valid_r <= 1'b0;
      start_r     <= 1'b0;
      stop_r      <= 1'b0;
      busy_r      <= 1'b0;
      drop_r      <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      mode_r      <= mode_nxt;
      cnt_r       <= cnt_nxt;
      si_r        <= si_nxt;
      len_r       <= len_nxt;
      crc_r       <= crc_nxt;
      exc_r       <= exc_nxt;
      words_r     <= words_nxt;
      idx_r       <= idx_nxt;
      req_r       <= req_nxt;
      req_valid_r <= req_valid_nxt;
      start_r     <= start_nxt;
      stop_r      <= stop_nxt;
      busy_r      <= busy_nxt;
      drop_r      <= drop_nxt;
    end
  end

  // Storage arrays carry no reset; they are always written before they are read.
  always_ff @(posedge clk_sys_i) begin
    if (buf_we) rx_buf[cnt_r] <= rx_byte_i;
    if (mem_we) rd_mem[idx_r[6:0]] <= app_rsp_i.rdata;
  end

  assign app_req_o       = req_r;
  assign app_req_valid_o = req_valid_r;
  assign motor_start_o   = start_r;
  assign motor_stop_o    = stop_r;
  assign busy_o          = busy_r;
  assign frame_drop_o    = drop_r;

  // The FIFO lets the reply builder run ahead of a slow transmitter and stall when full.
  tx_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .clk_sys_i  (clk_sys_i),
    .reset_n_i  (reset_n_i),
    .in_data_i  (tx_sel),
    .in_valid_i (state_r == modbus_pkg::ST_SEND),
    .in_ready_o (in_ready),
    .out_data_o (tx_byte_o),
    .out_valid_o(tx_valid_o),
    .out_ready_i(tx_ready_i)
  );

  start_cause_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    motor_start_o |-> $past(fc) == modbus_pkg::FC_SPECIAL && $past(rx_buf[3]) == 8'h1A)
    else $error("start pulse without start query");
  stop_cause_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    motor_stop_o |-> $past(rx_buf[3]) == 8'h1B && $past(rx_buf[2]) == 8'h30)
    else $error("stop pulse without stop query");
  exc_flag_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    push && mode_r == modbus_pkg::MODE_EXC && si_r == 9'h001 |-> tx_sel == (fc | 8'h80))
    else $error("exception function byte lacks flag");
  byte_count_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    push && mode_r == modbus_pkg::MODE_READ && si_r == 9'h002
    |-> tx_sel == 8'(len_r - 9'h003))
    else $error("read byte count wrong");
  read_limit_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    app_req_valid_o && app_req_o.op == modbus_pkg::OP_READ |-> words_r <= modbus_pkg::MAX_REGS)
    else $error("read beyond register limit");
  bad_drop_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    state_r == modbus_pkg::ST_CHK && crc_r != 16'h0000
    |=> state_r == modbus_pkg::ST_RX && frame_drop_o ##1 !tx_valid_o)
    else $error("bad frame not dropped");
  echo_exact_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    push && mode_r == modbus_pkg::MODE_ECHO && fc != modbus_pkg::FC_WRITE_MANY
    |-> tx_sel == rx_buf[si_r])
    else $error("echo reply differs from query");
  fc4_read_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    app_req_valid_o && fc == modbus_pkg::FC_READ_INPUT |-> app_req_o.op == modbus_pkg::OP_READ)
    else $error("code 4 not handled as read");
endmodule : modbus_rtu_slave_frame_handler
`default_nettype wire

// file: hw/unused_placeholder_never.sv
`default_nettype none
`default_nettype wire

// file: dv/master_model.sv
// Bus master model: sends query frames with their CRC and collects the reply bytes.
// Assumes the bench calls send only while the handler is idle and sets stall between frames.
`default_nettype none
module master_model (
  // Clock.
  input  wire logic       clk_sys_i,
  // Query stream into the handler.
  output logic [7:0]      rx_byte_o,
  output logic            rx_valid_o,
  output logic            rx_end_o,
  // Reply stream out of the handler.
  input  wire logic [7:0] tx_byte_i,
  input  wire logic       tx_valid_i,
  output logic            tx_ready_o,
  // Consumer back-pressure set by the bench.
  input  wire logic       stall_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got_q[$];

  initial begin
    rx_byte_o = 8'h00;
    rx_valid_o = 1'b0;
    rx_end_o = 1'b0;
  end

  function automatic logic [15:0] crc16(input logic [7:0] b[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (b[i]) begin
      c ^= {8'h00, b[i]};
      for (int k = 0; k < 8; k++) begin
        c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
      end
    end
    return c;
  endfunction : crc16

  // A corrupted CRC lets the bench see that such frames are dropped without a reply.
  task automatic send(input logic [7:0] q[$], input bit bad);
    logic [15:0] c;
    c = crc16(q) ^ {15'h0000, bad};
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    foreach (q[i]) begin
      @(negedge clk_sys_i);
      rx_byte_o = q[i];
      rx_valid_o = 1'b1;
      rx_end_o = (i == q.size() - 1);
    end
    @(negedge clk_sys_i);
    // An idle line shows a changing value so that a stale byte is never mistaken for data.
    rx_byte_o = ~rx_byte_o;
    rx_valid_o = 1'b0;
    rx_end_o = 1'b0;
  endtask : send

  always @(negedge clk_sys_i) begin
    tx_ready_o <= ~stall_i;
  end

  always @(posedge clk_sys_i) begin
    if (tx_valid_i === 1'b1 && tx_ready_o === 1'b1) begin
      got_q.push_back(tx_byte_i);
    end
  end
endmodule : master_model
`default_nettype wire

// file: dv/tb_top.sv
// Self-checking bench for the frame handler: query table, then drops, stalls and reset.
// Assumes the handler at slave address F7 and an application that answers one cycle late.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 clk_sys_i, reset_n_i, rx_valid_i, rx_end_i, tx_ready_i, tx_valid_o;
  logic                 busy_o, frame_drop_o, motor_start_o, motor_stop_o, app_req_valid_o;
  logic [7:0]           rx_byte_i, slave_addr_i, tx_byte_o;
  logic                 stall;
  modbus_pkg::app_req_t app_req;
  modbus_pkg::app_rsp_t app_rsp;
  int                   n_mismatch, checks_done, cycles, n_start, n_stop, n_drop;
  typedef struct packed {
    logic [79:0] q;
    logic [3:0]  qn;
    logic [95:0] r;
    logic [3:0]  rn;
    logic [1:0]  mot;
  } row_t;
  row_t rows [12] = '{
    '{80'hF70303E90002, 4'h6, 96'hF7030459E959EA, 4'h7, 2'h0},
    '{80'hF70403E90002, 4'h6, 96'hF7040459E959EA, 4'h7, 2'h0},
    '{80'hF70501000100, 4'h6, 96'hF70501000100, 4'h6, 2'h0},
    '{80'hF705040019000000, 4'h8, 96'hF705040019000000, 4'h8, 2'h0},
    '{80'hF70603E90032, 4'h6, 96'hF70603E90032, 4'h6, 2'h0},
    '{80'hF709301A, 4'h4, 96'hF709301A, 4'h4, 2'h1},
    '{80'hF709301B, 4'h4, 96'hF709301B, 4'h4, 2'h2},
    '{80'hF70700000001, 4'h6, 96'hF78701, 4'h3, 2'h0},
    '{80'hF7030000007E, 4'h6, 96'hF78310, 4'h3, 2'h0},
    '{80'hF70300000000, 4'h6, 96'hF78303, 4'h3, 2'h0},
    '{80'hF703FFFF0001, 4'h6, 96'hF78302, 4'h3, 2'h0},
    '{80'hF71003E9000102000F, 4'h9, 96'hF71003E90001, 4'h6, 2'h0}
  };

  modbus_rtu_slave_frame_handler #(.FIFO_DEPTH(16)) u_modbus_rtu_slave_frame_handler (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .rx_byte_i(rx_byte_i),
    .rx_valid_i(rx_valid_i), .rx_end_i(rx_end_i), .slave_addr_i(slave_addr_i),
    .app_req_o(app_req), .app_req_valid_o(app_req_valid_o), .app_rsp_i(app_rsp),
    .motor_start_o(motor_start_o), .motor_stop_o(motor_stop_o), .tx_byte_o(tx_byte_o),
    .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i), .busy_o(busy_o),
    .frame_drop_o(frame_drop_o));
  master_model u_master_model (
    .clk_sys_i(clk_sys_i), .rx_byte_o(rx_byte_i), .rx_valid_o(rx_valid_i),
    .rx_end_o(rx_end_i), .tx_byte_i(tx_byte_o), .tx_valid_i(tx_valid_o),
    .tx_ready_o(tx_ready_i), .stall_i(stall));

  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  // Register contents are a fixed function of the address; address FFFF is refused.
  function automatic logic [15:0] reg_val(input logic [15:0] a);
    return a ^ 16'h5A00;
  endfunction : reg_val

  initial begin
    app_rsp = '0;
    forever begin
      @(negedge clk_sys_i);
      if (app_req_valid_o === 1'b1) begin
        app_rsp.ack = 1'b1;
        app_rsp.err = (app_req.addr === 16'hFFFF);
        app_rsp.exc = modbus_pkg::EX_ADDR;
        app_rsp.rdata = reg_val(app_req.addr);
        @(negedge clk_sys_i);
        app_rsp = '0;
        while (app_req_valid_o === 1'b1) begin
          @(negedge clk_sys_i);
        end
      end
    end
  end

  always @(posedge clk_sys_i) begin
    cycles++;
    n_start += (motor_start_o === 1'b1);
    n_stop += (motor_stop_o === 1'b1);
    n_drop += (frame_drop_o === 1'b1);
    if (cycles == 20000) begin
      n_mismatch++;
      summarize();
    end
  end

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : check

  task automatic wait_idle();
    for (int w = 0; w < 500 && busy_o !== 1'b0; w++) begin
      @(negedge clk_sys_i);
    end
  endtask : wait_idle

  // An empty expectation means that no reply at all may appear.
  task automatic expect_reply(input logic [7:0] e[$]);
    logic [15:0] c;
    c = u_master_model.crc16(e);
    if (e.size() != 0) begin
      e.push_back(c[7:0]);
      e.push_back(c[15:8]);
    end
    for (int w = 0; w < 3000 && u_master_model.got_q.size() < e.size(); w++) begin
      @(posedge clk_sys_i);
    end
    repeat (20) @(posedge clk_sys_i);
    check("reply length", 16'(e.size()), 16'(u_master_model.got_q.size()));
    foreach (e[i]) begin
      if (i < u_master_model.got_q.size()) begin
        check("reply byte", {8'h00, e[i]}, {8'h00, u_master_model.got_q[i]});
      end
    end
    u_master_model.got_q.delete();
  endtask : expect_reply

  task automatic summarize();
    $display("checks %0d, mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize

  initial begin
    logic [7:0] q[$];
    logic [7:0] e[$];
    int         s0, s1, d0;
    logic [15:0] v;
    reset_n_i = 1'b0;
    slave_addr_i = 8'hF7;
    stall = 1'b0;
    repeat (20) @(negedge clk_sys_i);
    check("outputs in reset", 16'h0000,
          {10'h000, tx_valid_o, busy_o, app_req_valid_o, motor_start_o, motor_stop_o,
           frame_drop_o});
    reset_n_i = 1'b1;
    $display("test reset done");
    foreach (rows[t]) begin
      q.delete();
      e.delete();
      for (int i = 0; i < rows[t].qn; i++) begin
        q.push_back(rows[t].q[8*(rows[t].qn-1-i) +: 8]);
      end
      for (int i = 0; i < rows[t].rn; i++) begin
        e.push_back(rows[t].r[8*(rows[t].rn-1-i) +: 8]);
      end
      s0 = n_start;
      s1 = n_stop;
      wait_idle();
      u_master_model.send(q, 1'b0);
      expect_reply(e);
      check("start pulses", 16'(n_start - s0), {15'h0000, rows[t].mot[0]});
      check("stop pulses", 16'(n_stop - s1), {15'h0000, rows[t].mot[1]});
      $display("test row %0d done", t);
    end
    // Bad CRC, then a foreign slave address: both dropped without any reply.
    d0 = n_drop;
    e.delete();
    wait_idle();
    u_master_model.send('{8'hF7, 8'h09, 8'h30, 8'h1A}, 1'b1);
    expect_reply(e);
    wait_idle();
    u_master_model.send('{8'h11, 8'h09, 8'h30, 8'h1A}, 1'b0);
    expect_reply(e);
    check("drop pulses", 16'(n_drop - d0), 16'h0002);
    check("no start", 16'(n_start - s0), {15'h0000, rows[11].mot[0]});
    $display("test drops done");
    // Largest read with the consumer stalled: the reply overfills the FIFO and must wait.
    stall = 1'b1;
    wait_idle();
    u_master_model.send('{8'hF7, 8'h03, 8'h00, 8'h00, 8'h00, 8'h7D}, 1'b0);
    repeat (600) @(negedge clk_sys_i);
    check("stalled busy", 16'h0001, {15'h0000, busy_o});
    check("stalled valid", 16'h0001, {15'h0000, tx_valid_o});
    check("stalled taken", 16'h0000, 16'(u_master_model.got_q.size()));
    e = '{8'hF7, 8'h03, 8'hFA};
    for (int i = 0; i < 125; i++) begin
      v = reg_val(16'(i));
      e.push_back(v[15:8]);
      e.push_back(v[7:0]);
    end
    stall = 1'b0;
    expect_reply(e);
    $display("test stall done");
    // Reset in mid-run while a reply waits in the stalled FIFO: it must vanish, and the
    // next query must be served normally.
    stall = 1'b1;
    wait_idle();
    u_master_model.send(q, 1'b0);
    repeat (40) @(negedge clk_sys_i);
    check("held reply", 16'h0001, {15'h0000, tx_valid_o});
    reset_n_i = 1'b0;
    @(negedge clk_sys_i);
    check("reset flush", 16'h0000, {14'h0000, tx_valid_o, busy_o});
    reset_n_i = 1'b1;
    stall = 1'b0;
    u_master_model.got_q.delete();
    wait_idle();
    u_master_model.send(q, 1'b0);
    e = '{8'hF7, 8'h10, 8'h03, 8'hE9, 8'h00, 8'h01};
    expect_reply(e);
    $display("test mid-run reset done");
    summarize();
  end
endmodule : tb_top
`default_nettype wire
